/* File: design/eplk_pkg.sv */
// Constants, modes and carrier structs for the code memory lock and programming block.
// Assumes the pins are sampled synchronously to ref_clk by the surrounding pad logic.
package eplk_pkg;
  // Array geometry
  localparam int ADDR_W = 15;
  localparam int CODE_DEPTH = 32768;
  localparam int ENC_DEPTH = 64;
  localparam int ENC_AW = 6;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Signature locations and contents (contents arbitrary, not a real part's codes)
  localparam logic [14:0] SIG_ADDR0 = 15'h0030;
  localparam logic [14:0] SIG_ADDR1 = 15'h0031;
  localparam logic [14:0] SIG_ADDR2 = 15'h0060;
  localparam logic [14:0] SIG_ADDR3 = 15'h0061;
  localparam logic [7:0] SIG_BYTE0 = 8'h5A;
  localparam logic [7:0] SIG_BYTE1 = 8'hA5;
  localparam logic [7:0] SIG_BYTE2 = 8'h3C;
  localparam logic [7:0] SIG_BYTE3 = 8'hC3;

  // Mode select patterns {p2.6, p2.7, p3.3, p3.6, p3.7} with high programming voltage
  localparam logic [4:0] SEL_PROG_CODE = 5'h0F;
  localparam logic [4:0] SEL_PROG_ENC = 5'h0D;
  localparam logic [4:0] SEL_LOCK_ONE = 5'h1F;
  localparam logic [4:0] SEL_LOCK_TWO = 5'h1C;
  localparam logic [4:0] SEL_LOCK_THREE = 5'h16;

  // Wishbone register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTRL_ERASE = 0;
  localparam int CTRL_SIZE32 = 1;
  localparam logic CTRL_SIZE32_RESET = 1'b1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_LOCK_LSB = 1;
  localparam int STAT_LEVEL_LSB = 4;
  localparam int STAT_EXT_LATCH = 7;
  localparam int STAT_SIZE32 = 8;

  typedef enum logic [2:0] {
    MODE_IDLE, MODE_PROG_CODE, MODE_VERIFY, MODE_PROG_ENC,
    MODE_SIG, MODE_LOCK_ONE, MODE_LOCK_TWO, MODE_LOCK_THREE
  } eplk_mode_type;

  typedef struct packed {
    logic rst_pin;
    logic program_store_strobe;
    logic programming_strobe;
    logic programming_voltage_pin;
    logic vpp_high;
    logic [7:0] p0_in;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
  } eplk_pins_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } eplk_wb_req_type;

  typedef struct packed {
    logic rd;
    logic from_ext;
    logic [14:0] addr;
  } eplk_core_req_type;
endpackage : eplk_pkg

/* File: design/eplk_byte_mem.sv */
// Byte-wide nonvolatile array with EPROM-style programming (bits only go 1 to 0).
// Assumes one access per cycle; read data appears one cycle after the address.
`timescale 1ns/1ps
module eplk_byte_mem #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic ref_clk,
  input wire logic [AW-1:0] addr,
  input wire logic we,
  input wire logic erase,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  // Shipped blank: every cell reads all ones; set at declaration so the
  // clocked process below stays the only writer of the array
  logic [7:0] cells [DEPTH] = '{default: eplk_pkg::ERASED_BYTE};

  // Programming can only clear bits; erase restores ones
  always_ff @(posedge ref_clk) begin
    if (erase) begin
      cells[addr] <= eplk_pkg::ERASED_BYTE;
    end else if (we) begin
      cells[addr] <= cells[addr] & wdata;
    end
    rdata <= cells[addr];
  end
endmodule : eplk_byte_mem

/* File: design/eplk_access.sv */
// Programming, verify, encryption and lock control for the on-chip code memory.
// Assumes pins are synchronous to ref_clk and a Wishbone classic master.
// Function
// - 64-byte encryption array, starts all ones
// - low six address bits pick encryption byte
// - verify byte is XNOR of code, encryption
// - level 2: block reads, latch pin, no programming
// - level 3: level 2 plus verify disabled
// - level 4: level 3 plus no external execution
// - address from port 1, port 2, p3.4
// - data on port 0 both ways
// - code write: high voltage, strobe pulse
// - encryption write: p3.6 low, 0-3Fh
// - lock bit writes use listed pin patterns
// - verify and signature read pin patterns
// - no direct encryption array read mode
// - four fixed signature bytes, read only
// - erase clears code, encryption, lock bits
// - signatures at 30h, 31h, 60h, 61h
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module eplk_access #(
  parameter int ERASE_WORDS = eplk_pkg::CODE_DEPTH
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire eplk_pkg::eplk_pins_type pins,
  output logic [7:0] p0_out,
  output logic p0_oe,
  input wire eplk_pkg::eplk_wb_req_type wb_req,
  output logic wb_ack,
  output logic [31:0] wb_dat_o,
  input wire eplk_pkg::eplk_core_req_type core_req,
  output logic [7:0] core_data,
  output logic core_valid,
  output logic core_blocked,
  output logic ext_exec_allow,
  output logic external_access_latched
);
  eplk_pkg::eplk_mode_type mode;
  logic [4:0] sel_bits;
  logic [14:0] pin_addr;
  logic [14:0] mem_addr;
  logic [5:0] enc_addr;
  logic [7:0] code_rdata;
  logic [7:0] enc_rdata;
  logic [7:0] xnor_byte;
  logic [7:0] sig_byte;
  logic [2:0] level;
  logic prog_locked;
  logic verify_locked;
  logic strobe_fall;
  logic code_we;
  logic enc_we;
  logic wb_fire;
  logic erase_start;
  logic core_go;
  logic strobe_q, next_strobe_q;
  logic lock_bit_one, next_lock_bit_one;
  logic lock_bit_two, next_lock_bit_two;
  logic lock_bit_three, next_lock_bit_three;
  logic erasing, next_erasing;
  logic [14:0] erase_cnt, next_erase_cnt;
  logic size32, next_size32;
  logic next_external_access_latched;
  logic next_ext_exec_allow;
  logic next_wb_ack;
  logic [31:0] next_wb_dat_o;
  logic [7:0] next_p0_out;
  logic next_p0_oe;
  logic core_pend, next_core_pend;
  logic core_pend_blk, next_core_pend_blk;
  logic [7:0] next_core_data;
  logic next_core_valid;
  logic next_core_blocked;

  // Mode decode from static control pins; anything unlisted is idle
  always_comb begin
    sel_bits = {pins.p2[6], pins.p2[7], pins.p3[3], pins.p3[6], pins.p3[7]};
    mode = eplk_pkg::MODE_IDLE;
    if (pins.rst_pin && !pins.program_store_strobe) begin
      if (pins.vpp_high) begin
        case (sel_bits)
          eplk_pkg::SEL_PROG_CODE: mode = eplk_pkg::MODE_PROG_CODE;
          eplk_pkg::SEL_PROG_ENC: mode = eplk_pkg::MODE_PROG_ENC;
          eplk_pkg::SEL_LOCK_ONE: mode = eplk_pkg::MODE_LOCK_ONE;
          eplk_pkg::SEL_LOCK_TWO: mode = eplk_pkg::MODE_LOCK_TWO;
          eplk_pkg::SEL_LOCK_THREE: mode = eplk_pkg::MODE_LOCK_THREE;
          default: mode = eplk_pkg::MODE_IDLE;
        endcase
      end else if (pins.programming_strobe && pins.programming_voltage_pin &&
                   !pins.p2[6] && !pins.p3[3]) begin
        // p2.7 is a don't-care in both read modes
        if (pins.p3[6] && pins.p3[7]) begin
          mode = eplk_pkg::MODE_VERIFY;
        end else if (!pins.p3[6] && !pins.p3[7]) begin
          mode = eplk_pkg::MODE_SIG;
        end
      end
    end
  end

  // Address and write qualifiers; the 16 KB variant ignores p3.4
  always_comb begin
    pin_addr = {pins.p3[4] & size32, pins.p2[5:0], pins.p1};
    level = lock_bit_three ? 3'h4 : (lock_bit_two ? 3'h3 : (lock_bit_one ? 3'h2 : 3'h1));
    prog_locked = lock_bit_one | lock_bit_two | lock_bit_three;
    verify_locked = lock_bit_two | lock_bit_three;
    strobe_fall = strobe_q && !pins.programming_strobe;
    code_we = !erasing && strobe_fall && !prog_locked &&
              (mode == eplk_pkg::MODE_PROG_CODE);
    enc_we = !erasing && strobe_fall && !prog_locked &&
             (mode == eplk_pkg::MODE_PROG_ENC);
    core_go = core_req.rd && !pins.rst_pin && !erasing;
    mem_addr = erasing ? erase_cnt : (pins.rst_pin ? pin_addr :
               {core_req.addr[14] & size32, core_req.addr[13:0]});
    enc_addr = erasing ? erase_cnt[5:0] : pin_addr[5:0];
    xnor_byte = ~(code_rdata ^ enc_rdata);
    wb_fire = wb_req.cyc && wb_req.stb && wb_ack;
    erase_start = wb_fire && wb_req.we && wb_req.sel[0] && (wb_req.adr == eplk_pkg::REG_CTRL) &&
                  wb_req.dat[eplk_pkg::CTRL_ERASE] && !erasing;
  end

  // Signature lookup; other addresses read as blank
  always_comb begin
    case (pin_addr)
      eplk_pkg::SIG_ADDR0: sig_byte = eplk_pkg::SIG_BYTE0;
      eplk_pkg::SIG_ADDR1: sig_byte = eplk_pkg::SIG_BYTE1;
      eplk_pkg::SIG_ADDR2: sig_byte = eplk_pkg::SIG_BYTE2;
      eplk_pkg::SIG_ADDR3: sig_byte = eplk_pkg::SIG_BYTE3;
      default: sig_byte = eplk_pkg::ERASED_BYTE;
    endcase
  end

  eplk_byte_mem #(.DEPTH(eplk_pkg::CODE_DEPTH), .AW(eplk_pkg::ADDR_W)) u_code (
    .ref_clk(ref_clk),
    .addr(mem_addr),
    .we(code_we),
    .erase(erasing),
    .wdata(pins.p0_in),
    .rdata(code_rdata)
  );

  // Encryption array: written only, never routed straight to the pins
  eplk_byte_mem #(.DEPTH(eplk_pkg::ENC_DEPTH), .AW(eplk_pkg::ENC_AW)) u_enc (
    .ref_clk(ref_clk),
    .addr(enc_addr),
    .we(enc_we),
    .erase(erasing),
    .wdata(pins.p0_in),
    .rdata(enc_rdata)
  );

  // Lock bits, erase sweep, strobe edge and latched external-access level
  always_comb begin
    next_strobe_q = pins.programming_strobe;
    next_lock_bit_one = lock_bit_one;
    next_lock_bit_two = lock_bit_two;
    next_lock_bit_three = lock_bit_three;
    next_erasing = erasing;
    next_erase_cnt = '0;
    next_size32 = size32;
    if (erase_start) begin
      next_erasing = 1'b1;
      next_lock_bit_one = 1'b0;
      next_lock_bit_two = 1'b0;
      next_lock_bit_three = 1'b0;
    end else if (erasing) begin
      next_erase_cnt = erase_cnt + 15'h0001;
      if (erase_cnt == 15'(ERASE_WORDS - 1)) begin
        next_erasing = 1'b0;
      end
    end else if (strobe_fall) begin
      // Lock bits can be raised when no erase is running; set bits stay set until an erase or sys_rst
      if (mode == eplk_pkg::MODE_LOCK_ONE) next_lock_bit_one = 1'b1;
      if (mode == eplk_pkg::MODE_LOCK_TWO) next_lock_bit_two = 1'b1;
      if (mode == eplk_pkg::MODE_LOCK_THREE) next_lock_bit_three = 1'b1;
    end
    if (wb_fire && wb_req.we && wb_req.sel[0] && (wb_req.adr == eplk_pkg::REG_CTRL)) begin
      next_size32 = wb_req.dat[eplk_pkg::CTRL_SIZE32];
    end
    // Locked parts freeze the level seen while reset is held
    if (!prog_locked || pins.rst_pin) begin
      next_external_access_latched = pins.programming_voltage_pin;
    end else begin
      next_external_access_latched = external_access_latched;
    end
    next_ext_exec_allow = !lock_bit_three;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      strobe_q <= 1'b1;
      lock_bit_one <= 1'b0;
      lock_bit_two <= 1'b0;
      lock_bit_three <= 1'b0;
      erasing <= 1'b0;
      erase_cnt <= '0;
      size32 <= eplk_pkg::CTRL_SIZE32_RESET;
      external_access_latched <= 1'b0;
      ext_exec_allow <= 1'b1;
    end else begin
      strobe_q <= next_strobe_q;
      lock_bit_one <= next_lock_bit_one;
      lock_bit_two <= next_lock_bit_two;
      lock_bit_three <= next_lock_bit_three;
      erasing <= next_erasing;
      erase_cnt <= next_erase_cnt;
      size32 <= next_size32;
      external_access_latched <= next_external_access_latched;
      ext_exec_allow <= next_ext_exec_allow;
    end
  end

  // Port 0 drive; no mode returns the encryption array alone
  always_comb begin
    next_p0_oe = !erasing && ((mode == eplk_pkg::MODE_VERIFY) || (mode == eplk_pkg::MODE_SIG));
    next_p0_out = eplk_pkg::ERASED_BYTE;
    if (mode == eplk_pkg::MODE_VERIFY) begin
      next_p0_out = verify_locked ? eplk_pkg::ERASED_BYTE : xnor_byte;
    end else if (mode == eplk_pkg::MODE_SIG) begin
      next_p0_out = sig_byte;
    end
  end

  // Core table reads: blocked from external code once any lock is set
  always_comb begin
    next_core_pend = core_go;
    next_core_pend_blk = core_go && core_req.from_ext && prog_locked;
    next_core_valid = core_pend;
    next_core_blocked = core_pend && core_pend_blk;
    next_core_data = core_data;
    if (core_pend) begin
      next_core_data = core_pend_blk ? eplk_pkg::ERASED_BYTE : code_rdata;
    end
  end

  // Wishbone slave: one-cycle ack, unmapped reads zero, only control register writes act
  always_comb begin
    next_wb_ack = wb_req.cyc && wb_req.stb && !wb_ack;
    next_wb_dat_o = '0;
    if (wb_req.adr == eplk_pkg::REG_CTRL) begin
      next_wb_dat_o[eplk_pkg::CTRL_SIZE32] = size32;
    end else if (wb_req.adr == eplk_pkg::REG_STATUS) begin
      next_wb_dat_o[eplk_pkg::STAT_BUSY] = erasing;
      next_wb_dat_o[eplk_pkg::STAT_LOCK_LSB +: 3] = {lock_bit_three, lock_bit_two, lock_bit_one};
      next_wb_dat_o[eplk_pkg::STAT_LEVEL_LSB +: 3] = level;
      next_wb_dat_o[eplk_pkg::STAT_EXT_LATCH] = external_access_latched;
      next_wb_dat_o[eplk_pkg::STAT_SIZE32] = size32;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      p0_out <= eplk_pkg::ERASED_BYTE;
      p0_oe <= 1'b0;
      core_pend <= 1'b0;
      core_pend_blk <= 1'b0;
      core_data <= eplk_pkg::ERASED_BYTE;
      core_valid <= 1'b0;
      core_blocked <= 1'b0;
      wb_ack <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      p0_out <= next_p0_out;
      p0_oe <= next_p0_oe;
      core_pend <= next_core_pend;
      core_pend_blk <= next_core_pend_blk;
      core_data <= next_core_data;
      core_valid <= next_core_valid;
      core_blocked <= next_core_blocked;
      wb_ack <= next_wb_ack;
      wb_dat_o <= next_wb_dat_o;
    end
  end

  // Checks on the lock, verify and read paths
  sequence s_ext_read_locked;
    core_go && core_req.from_ext && prog_locked;
  endsequence

  sequence s_erase_kick;
    erase_start;
  endsequence

  a_verify_locked_ones: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == eplk_pkg::MODE_VERIFY && verify_locked) |=> (p0_out == 8'hFF))
    else $error("locked verify did not return all ones");

  a_verify_xnor_data: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == eplk_pkg::MODE_VERIFY && !verify_locked) |=> (p0_out == $past(xnor_byte)))
    else $error("verify byte is not the xnor of code and key");

  a_code_write_locked: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (strobe_fall && prog_locked && mode == eplk_pkg::MODE_PROG_CODE) |-> !code_we && !enc_we)
    else $error("programming accepted while locked");

  a_lock_stays_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (lock_bit_one && !erase_start) |=> lock_bit_one)
    else $error("lock bit one dropped without erase");

  a_erase_clears_all: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_erase_kick |=> erasing && !lock_bit_one && !lock_bit_two && !lock_bit_three)
    else $error("erase did not clear the lock bits");

  a_ext_exec_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    lock_bit_three |=> !ext_exec_allow)
    else $error("external execution allowed at level four");

  a_table_read_block: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_ext_read_locked |-> ##2 (core_valid && core_blocked && core_data == 8'hFF))
    else $error("external table read was not blocked");

  a_sig_first_byte: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == eplk_pkg::MODE_SIG && pin_addr == 15'h0030) |=> (p0_out == eplk_pkg::SIG_BYTE0))
    else $error("signature byte at 30h wrong");

  a_enc_key_pick: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !erasing |-> (enc_addr == pin_addr[5:0]))
    else $error("encryption byte not picked by low address bits");

  a_wb_ack_single: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wb_ack |=> !wb_ack)
    else $error("ack held longer than one cycle");
endmodule : eplk_access

/* File: bench/eplk_programmer.sv */
// External programmer model driving the device pins for program, verify and run.
// Assumes the device answers on port 0 two cycles after a stable verify address.
`timescale 1ns/1ps
module eplk_programmer (
  input wire logic ref_clk,
  input wire logic [7:0] p0_out,
  input wire logic p0_oe,
  output eplk_pkg::eplk_pins_type pins
);
  eplk_pkg::eplk_pins_type drv;
  logic drv_en;
  logic [7:0] last_data = 8'h00;

  // Port 0 floats when nobody drives it, so show a level that changes every cycle
  always_comb begin
    pins = drv;
    pins.p0_in = p0_oe ? p0_out : (drv_en ? drv.p0_in : ~last_data);
  end

  // Remember the wire level for the floating pattern
  always_ff @(posedge ref_clk) begin
    last_data <= pins.p0_in;
  end

  // Idle state at time zero: device held in programming reset
  initial begin
    drv = '0;
    drv.rst_pin = 1'b1;
    drv.programming_strobe = 1'b1;
    drv_en = 1'b0;
  end

  // Static mode pins, sel is {p2.6, p2.7, p3.3, p3.6, p3.7}
  task set_lines(input logic [4:0] sel, input logic [14:0] addr, input logic vpp);
    drv.rst_pin <= 1'b1;
    drv.program_store_strobe <= 1'b0;
    drv.programming_voltage_pin <= 1'b1;
    drv.vpp_high <= vpp;
    drv.programming_strobe <= 1'b1;
    drv.p1 <= addr[7:0];
    drv.p2 <= {sel[3], sel[4], addr[13:8]};
    drv.p3 <= {sel[0], sel[1], 1'b0, addr[14], sel[2], 3'h0};
  endtask : set_lines

  // One strobe pulse, strobe back high before pins change again
  task burn(input logic [4:0] sel, input logic [14:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    set_lines(sel, addr, 1'b1);
    drv.p0_in <= data;
    drv_en <= 1'b1;
    @(posedge ref_clk);
    drv.programming_strobe <= 1'b0;
    @(posedge ref_clk);
    drv.programming_strobe <= 1'b1;
    @(posedge ref_clk);
    drv_en <= 1'b0;
    drv.vpp_high <= 1'b0;
  endtask : burn

  // Verify or signature read; waits past the two-cycle answer before sampling
  task verify(input logic sig, input logic [14:0] addr, output logic [7:0] data);
    @(posedge ref_clk);
    set_lines(sig ? 5'h08 : 5'h0B, addr, 1'b0);
    repeat (3) @(posedge ref_clk);
    #1;
    data = p0_oe ? p0_out : 8'hXX;
  endtask : verify

  // Release the device to run with the given external-access level
  task run_mode(input logic ea);
    @(posedge ref_clk);
    drv.rst_pin <= 1'b0;
    drv.programming_voltage_pin <= ea;
    drv.vpp_high <= 1'b0;
  endtask : run_mode
endmodule : eplk_programmer

/* File: bench/eplk_access_tb.sv */
// Self-checking bench: programs, verifies, locks and erases through pins and Wishbone.
// Assumes the programmer model in eplk_programmer and a short erase sweep of 64.
`timescale 1ns/1ps
module eplk_access_tb;
  logic ref_clk;
  logic sys_rst;
  eplk_pkg::eplk_pins_type pins;
  eplk_pkg::eplk_wb_req_type wb_req;
  eplk_pkg::eplk_core_req_type core_req;
  logic [7:0] p0_out;
  logic [7:0] core_data;
  logic [7:0] vd;
  logic [31:0] wb_dat_o;
  logic [31:0] q;
  logic p0_oe, wb_ack, core_valid, core_blocked, ext_exec_allow, external_access_latched, blk;
  int num_errors;
  int total_checks;

  eplk_access #(.ERASE_WORDS(64)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .pins(pins),
    .p0_out(p0_out), .p0_oe(p0_oe), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o),
    .core_req(core_req), .core_data(core_data), .core_valid(core_valid),
    .core_blocked(core_blocked), .ext_exec_allow(ext_exec_allow),
    .external_access_latched(external_access_latched));
  eplk_programmer prog (.ref_clk(ref_clk), .p0_out(p0_out), .p0_oe(p0_oe), .pins(pins));

  // Clock at 100 MHz
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // Classic single cycle; request held until ack is sampled high
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] r);
    int n;
    @(posedge ref_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    r = wb_dat_o;
    if (n >= 50) check("wb_ack", 32'(wb_ack), 32'h1);
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
  endtask : wb

  // Core table read, answer taken at the edge where valid is seen
  task core_read(input logic ext, input logic [14:0] addr, output logic [7:0] d, output logic b);
    int n;
    @(posedge ref_clk);
    core_req <= '{rd: 1'b1, from_ext: ext, addr: addr};
    @(posedge ref_clk);
    core_req.rd <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (core_valid !== 1'b1 && n < 10);
    d = core_data;
    b = core_blocked;
    check("core valid", 32'(core_valid), 32'h1);
  endtask : core_read

  task vchk(input logic sig, input logic [14:0] addr, input logic [7:0] exp);
    prog.verify(sig, addr, vd);
    check("p0 data", 32'(vd), 32'(exp));
  endtask : vchk

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #300000;
    num_errors++;
    $display("[ERR] watchdog expired");
    test_done();
  end

  initial begin
    sys_rst = 1'b1;
    wb_req = '0;
    core_req = '0;
    num_errors = 0;
    total_checks = 0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wb(1'b0, eplk_pkg::REG_STATUS, 32'h0, q);
    check("status", q & 32'h17F, 32'h110);
    wb(1'b0, 8'h08, 32'h0, q);
    check("unmapped", q, 32'h0);
    vchk(1'b0, 15'h0005, 8'hFF);
    // Filler codes are never FF so the key stays hidden
    prog.burn(eplk_pkg::SEL_PROG_CODE, 15'h4005, 8'h3C);
    prog.burn(eplk_pkg::SEL_PROG_CODE, 15'h0012, 8'hA7);
    vchk(1'b0, 15'h4005, 8'h3C);
    vchk(1'b0, 15'h0012, 8'hA7);
    prog.burn(eplk_pkg::SEL_PROG_ENC, 15'h0005, 8'h0F);
    prog.burn(eplk_pkg::SEL_PROG_ENC, 15'h003F, 8'h00);
    vchk(1'b0, 15'h4005, 8'hCC);
    vchk(1'b0, 15'h00BF, 8'h00);
    vchk(1'b0, 15'h0045, 8'h0F);
    // 16 KB part: A14 is ignored, so 4005h reads blank code at 0005h
    wb(1'b1, eplk_pkg::REG_CTRL, 32'h0, q);
    vchk(1'b0, 15'h4005, 8'h0F);
    wb(1'b0, eplk_pkg::REG_CTRL, 32'h0, q);
    check("ctrl size", q, 32'h0);
    wb(1'b1, eplk_pkg::REG_CTRL, 32'h2, q);
    wb(1'b0, eplk_pkg::REG_CTRL, 32'h0, q);
    check("ctrl size32", q, 32'h2);
    vchk(1'b0, 15'h0012, 8'hA7);
    vchk(1'b1, eplk_pkg::SIG_ADDR0, eplk_pkg::SIG_BYTE0);
    vchk(1'b1, eplk_pkg::SIG_ADDR1, eplk_pkg::SIG_BYTE1);
    vchk(1'b1, eplk_pkg::SIG_ADDR2, eplk_pkg::SIG_BYTE2);
    vchk(1'b1, eplk_pkg::SIG_ADDR3, eplk_pkg::SIG_BYTE3);
    vchk(1'b1, 15'h0005, 8'hFF);
    prog.run_mode(1'b1);
    core_read(1'b1, 15'h4005, vd, blk);
    check("core plain", {blk, vd}, 9'h03C);
    // Locks only once code and key are verified
    prog.burn(eplk_pkg::SEL_LOCK_ONE, 15'h0000, 8'h00);
    wb(1'b0, eplk_pkg::REG_STATUS, 32'h0, q);
    check("level two", q & 32'h7E, 32'h22);
    prog.burn(eplk_pkg::SEL_PROG_CODE, 15'h0012, 8'h00);
    prog.burn(eplk_pkg::SEL_PROG_ENC, 15'h0012, 8'h00);
    vchk(1'b0, 15'h0012, 8'hA7);
    prog.run_mode(1'b0);
    repeat (3) @(posedge ref_clk);
    check("ea latched", 32'(external_access_latched), 32'h1);
    core_read(1'b1, 15'h4005, vd, blk);
    check("core blocked", {blk, vd}, 9'h1FF);
    core_read(1'b0, 15'h4005, vd, blk);
    check("core internal", {blk, vd}, 9'h03C);
    prog.burn(eplk_pkg::SEL_LOCK_TWO, 15'h0000, 8'h00);
    wb(1'b0, eplk_pkg::REG_STATUS, 32'h0, q);
    check("level three", q & 32'h7E, 32'h36);
    vchk(1'b0, 15'h0012, 8'hFF);
    check("exec level3", 32'(ext_exec_allow), 32'h1);
    prog.burn(eplk_pkg::SEL_LOCK_THREE, 15'h0000, 8'h00);
    wb(1'b0, eplk_pkg::REG_STATUS, 32'h0, q);
    check("level four", q & 32'h7E, 32'h4E);
    check("exec level4", 32'(ext_exec_allow), 32'h0);
    wb(1'b1, eplk_pkg::REG_CTRL, 32'h3, q);
    for (int i = 0; i < 200; i++) begin
      wb(1'b0, eplk_pkg::REG_STATUS, 32'h0, q);
      if (q[eplk_pkg::STAT_BUSY] === 1'b0) break;
    end
    check("erased status", q & 32'h7F, 32'h10);
    check("exec erased", 32'(ext_exec_allow), 32'h1);
    vchk(1'b0, 15'h0012, 8'hFF);
    vchk(1'b0, 15'h0005, 8'hFF);
    test_done();
  end
endmodule : eplk_access_tb
